// ==== selftest_reset_monitor_regs_tb.sv ====
/*
  Self-checking bench: host end and device end joined by strm_if.
  Assumes shortened self-test and tick counts and ce held high.
*/
module selftest_reset_monitor_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import strm_pkg::*;

  localparam int          BITC = 40;
  localparam int          TICKC = 8;
  localparam logic [31:0] MASKS = 32'h8020_0021;

  logic        ref_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        ce = 1'b1;
  logic        rt_mode = 1'b0;
  logic        ctrl_bc_mode = 1'b0;
  logic        cmd_valid = 1'b0;
  logic [15:0] cmd_word = 16'h0000;
  logic        fault_a_pin = 1'b0;
  logic        fault_b_pin = 1'b0;
  logic        req_valid = 1'b0;
  logic        req_write = 1'b0;
  logic [4:0]  req_num = 5'h00;
  logic [15:0] req_data = 16'h0000;
  logic        req_ready, req_refused, rsp_valid, cmd_accept, mon_record;
  logic        codec_reset, cmd_halted, selftest_fail_pin;
  logic [15:0] rsp_data;
  logic [7:0]  time_tag;
  int          errors = 0;
  int          check_count = 0;

  always #5 ref_clk = ~ref_clk;

  strm_if strm_if_inst ();

  strm_dev #(.BIT_CYCLES(BITC), .TICK_CYCLES(TICKC)) strm_dev_inst (
    .ref_clk(ref_clk), .arst_n(arst_n), .ce(ce), .bus(strm_if_inst.dev),
    .ctrl_bc_mode(ctrl_bc_mode), .rt_mode(rt_mode), .cmd_valid(cmd_valid),
    .cmd_word(cmd_word), .fault_a_pin(fault_a_pin), .fault_b_pin(fault_b_pin),
    .cmd_accept(cmd_accept), .mon_record(mon_record), .time_tag(time_tag),
    .codec_reset(codec_reset), .cmd_halted(cmd_halted),
    .selftest_fail_pin(selftest_fail_pin));

  strm_host strm_host_inst (
    .ref_clk(ref_clk), .arst_n(arst_n), .ce(ce), .bus(strm_if_inst.host),
    .rt_mode(rt_mode), .req_valid(req_valid), .req_write(req_write),
    .req_num(req_num), .req_data(req_data), .req_ready(req_ready),
    .req_refused(req_refused), .rsp_valid(rsp_valid), .rsp_data(rsp_data));

  strm_checker #(.BIT_CYCLES(BITC)) strm_checker_inst (
    .ref_clk(ref_clk), .arst_n(arst_n), .reg_num(strm_if_inst.reg_num),
    .wr_stb(strm_if_inst.wr_stb), .rd_stb(strm_if_inst.rd_stb),
    .wdata(strm_if_inst.wdata), .rdata(strm_if_inst.rdata),
    .rd_valid(strm_if_inst.rd_valid));

  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : chk

  task automatic req(input logic wr, input logic [4:0] num, input logic [15:0] data);
    int n;
    n = 0;
    @(negedge ref_clk);
    while (req_ready !== 1'b1 && n < 50)
    begin
      @(negedge ref_clk);
      n++;
    end
    req_valid = 1'b1;
    req_write = wr;
    req_num = num;
    req_data = data;
    @(negedge ref_clk);
    req_valid = 1'b0;
  endtask : req

  task automatic rd(input logic [4:0] num, output logic [15:0] d);
    int n;
    n = 0;
    req(1'b0, num, 16'h0000);
    while (rsp_valid !== 1'b1 && n < 10)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    d = rsp_data;
    chk(n < 10, "read answer missing");
  endtask : rd

  // Sends one command word, returns with the monitor flag settled
  task automatic send_cmd(input logic [4:0] ta);
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd_word = {ta, 11'h000};
    @(negedge ref_clk);
    cmd_valid = 1'b0;
  endtask : send_cmd

  task automatic t_regs;
    logic [15:0] d;
    rd(REG_MASK_LO, d);
    chk(d === MASK_RST, "mask low reset value");
    rd(REG_MODE, d);
    chk(d[15:13] === MODE_RST, "mode reset value");
    rd(5'h1f, d);
    chk(d === 16'h0000, "unmapped read not zero");
    req(1'b1, REG_RSVD, 16'hffff);
    chk(req_refused === 1'b1, "reserved access not refused");
    req(1'b1, REG_MASK_LO, MASKS[15:0]);
    req(1'b1, REG_MASK_HI, MASKS[31:16]);
    rd(REG_MASK_HI, d);
    chk(d === MASKS[31:16], "mask high readback");
    $display("done: registers");
  endtask : t_regs

  task automatic t_timer;
    chk(time_tag > 8'h00, "time tag not running");
    req(1'b1, REG_TIMER_CLR, 16'h5a5a);
    repeat (2) @(posedge ref_clk);
    #1;
    chk(time_tag === 8'h00, "time tag not cleared");
    repeat (TICKC * 3 + 4) @(posedge ref_clk);
    #1;
    chk(time_tag === 8'h03, "time tag rate");
    repeat (TICKC * 256) @(posedge ref_clk);
    #1;
    chk(time_tag === 8'h03, "time tag width");
    $display("done: timer");
  endtask : t_timer

  task automatic t_softreset;
    logic [15:0] d;
    int          n;
    n = 0;
    req(1'b1, REG_SOFT_RST, 16'h1234);
    while (codec_reset !== 1'b1 && n < 10)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    n = 0;
    while (codec_reset === 1'b1 && n < 200)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk(n > 0 && n < 100, "programmed reset length");
    chk(cmd_halted === 1'b1, "commands not halted");
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    #1;
    chk(cmd_accept === 1'b0, "command taken while halted");
    rd(REG_MASK_LO, d);
    chk(d === MASKS[15:0], "mask lost by programmed reset");
    $display("done: programmed reset");
  endtask : t_softreset

  task automatic t_selftest(input logic fa, input logic fb);
    logic [15:0] d;
    int          n;
    @(negedge ref_clk);
    fault_a_pin = fa;
    fault_b_pin = fb;
    rt_mode = 1'b1;
    cmd_valid = 1'b0;
    req(1'b1, REG_BIT_START, {fa, fb, 14'h2c5});
    rd(REG_STATUS, d);
    chk(d[STS_BIT_BUSY] === 1'b1, "self-test not running");
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    #1;
    chk(cmd_accept === 1'b0, "command taken during self-test");
    n = 0;
    while (d[STS_BIT_BUSY] !== 1'b0 && n < 20)
    begin
      rd(REG_STATUS, d);
      n++;
    end
    chk(n < 20, "self-test never ended");
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    fault_a_pin = 1'b0;
    fault_b_pin = 1'b0;
    rt_mode = 1'b0;
    rd(REG_RESULT, d);
    chk(d[15:14] === {fb, fa}, "channel fail flags");
    chk(selftest_fail_pin === (fa | fb), "fail pin");
    $display("done: self-test");
  endtask : t_selftest

  task automatic t_monitor;
    logic [15:0] mode;
    logic        exp;
    for (int c = 0; c < 4; c++)
    begin
      mode = (c == 0) ? 16'ha000 : (c == 3) ? 16'h4000 : 16'hc000;
      @(negedge ref_clk);
      ctrl_bc_mode = (c == 2);
      req(1'b1, REG_MODE, mode);
      for (int ta = 0; ta < 32; ta++)
      begin
        exp = mode[15] && !ctrl_bc_mode && (mode[14] || (mode[13] && MASKS[ta]));
        send_cmd(ta[4:0]);
        chk(mon_record === exp, "monitor record");
      end
    end
    $display("done: monitor");
  endtask : t_monitor

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report

  initial
  begin
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
    arst_n = 1'b1;
    t_regs;
    t_timer;
    t_softreset;
    t_selftest(1'b1, 1'b0);
    t_selftest(1'b0, 1'b1);
    t_selftest(1'b0, 1'b0);
    t_monitor;
    final_report;
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    final_report;
  end
endmodule : selftest_reset_monitor_regs_tb

// ==== strm_dev.sv ====
/*
  Device end: self-test sequencer with internal wrap-around check,
  programmed reset, free-running time tag timer, monitor mode and
  terminal select masks, reached through the strm_if register port.
  Assumes command words arrive from same-clock decoder logic and that
  the fault injection pins come from outside and need synchronising.
*/
// Contract
// RULE1: Any write to self-test start begins test
// RULE2: Status shows test in progress while running
// RULE3: Host issues programmed reset before self-test start
// RULE4: Failure shown in result register and pin
// RULE5: Encoder looped back into both decoders
// RULE6: Bit 14 channel A, bit 15 channel B
// RULE7: RT mode ignores commands during self-test
// RULE8: Programmed reset resets codec under one microsecond
// RULE9: Programmed reset halts commands, keeps registers
// RULE10: Timer clear write zeroes tag, keeps counting
// RULE11: Eight-bit time tag advances every 64 us
// RULE12: Monitor needs select bit and control bit10 low
// RULE13: Monitor-all bit records every terminal
// RULE14: Host sets monitor-all or declared when enabling
// RULE15: Host clears monitor bits for RT operation
// RULE16: Low mask bit n selects terminal n
// RULE17: High mask bit k selects terminal k+16
// RULE18: Mask bits act independently in any combination
// RULE19: Host never touches the reserved register
// RULE20: Declared mode records only masked terminal addresses
module strm_dev
  import strm_pkg::*;
#(
  parameter int BIT_CYCLES  = strm_pkg::BIT_CYC,
  parameter int TICK_CYCLES = strm_pkg::TICK_CYC
)
(
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic        ce,
  strm_if.dev              bus,
  input  wire logic        ctrl_bc_mode,
  input  wire logic        rt_mode,
  input  wire logic        cmd_valid,
  input  wire logic [15:0] cmd_word,
  input  wire logic        fault_a_pin,
  input  wire logic        fault_b_pin,
  output logic             cmd_accept,
  output logic             mon_record,
  output logic [7:0]       time_tag,
  output logic             codec_reset,
  output logic             cmd_halted,
  output logic             selftest_fail_pin
);
  import strm_pkg::*;

  typedef struct packed {
    strm_dev_state_e        st;
    logic [BIT_CNT_W-1:0]   bit_cnt;
    logic [SRST_CNT_W-1:0]  srst_cnt;
    logic [7:0]             lfsr;
    logic [TICK_CNT_W-1:0]  tick_cnt;
    logic [7:0]             tag;
    logic [2:0]             mode;
    logic [15:0]            mask_lo;
    logic [15:0]            mask_hi;
    logic                   fail_a;
    logic                   fail_b;
    logic                   halted;
    logic [15:0]            rdata;
    logic                   rd_valid;
    logic                   mon_rec;
    logic                   fa_s1;
    logic                   fa_s2;
    logic                   fb_s1;
    logic                   fb_s2;
  } strm_dev_s;

  strm_dev_s state_reg;
  strm_dev_s state_next;

  logic       wr_bit;
  logic       wr_srst;
  logic       wr_tclr;
  logic       mon_en;
  logic       mon_hit;
  logic [4:0] cmd_ta;
  logic [31:0] mask_all;
  logic       enc_bit;
  logic       rx_a;
  logic       rx_b;

  assign wr_bit   = bus.wr_stb && (bus.reg_num == REG_BIT_START);
  assign wr_srst  = bus.wr_stb && (bus.reg_num == REG_SOFT_RST);
  assign wr_tclr  = bus.wr_stb && (bus.reg_num == REG_TIMER_CLR);
  assign cmd_ta   = cmd_word[CMD_TA_MSB:CMD_TA_LSB];
  assign mask_all = {state_reg.mask_hi, state_reg.mask_lo};

  // Monitor enable and terminal filter
  assign mon_en  = state_reg.mode[2] && !ctrl_bc_mode; // RULE12
  assign mon_hit = state_reg.mode[1] // RULE13
                   || (state_reg.mode[0] && mask_all[cmd_ta]); // RULE16 RULE17 RULE18 RULE20

  // Internal wrap-around: encoder bit looped into both decoders
  assign enc_bit = state_reg.lfsr[0]; // RULE5
  assign rx_a    = enc_bit ^ state_reg.fa_s2; // RULE5
  assign rx_b    = enc_bit ^ state_reg.fb_s2; // RULE5

  // Commands are dropped while halted, in reset, or in RT mode during self-test
  assign cmd_accept = cmd_valid && !state_reg.halted
                      && (state_reg.st != ST_SRST)
                      && !(rt_mode && (state_reg.st == ST_BIT)); // RULE7

  assign mon_record        = state_reg.mon_rec;
  assign time_tag          = state_reg.tag;
  assign codec_reset       = (state_reg.st == ST_SRST); // RULE8
  assign cmd_halted        = state_reg.halted;
  assign selftest_fail_pin = state_reg.fail_a || state_reg.fail_b; // RULE4
  assign bus.rdata         = state_reg.rdata;
  assign bus.rd_valid      = state_reg.rd_valid;

  always_comb
  begin
    state_next          = state_reg;
    state_next.rd_valid = 1'b0;
    state_next.mon_rec  = 1'b0;
    state_next.fa_s1    = fault_a_pin;
    state_next.fa_s2    = state_reg.fa_s1;
    state_next.fb_s1    = fault_b_pin;
    state_next.fb_s2    = state_reg.fb_s1;

    // Time tag timer
    if (wr_tclr)
    begin
      state_next.tag      = 8'h00; // RULE10
      state_next.tick_cnt = '0; // RULE10
    end
    else if (state_reg.tick_cnt == TICK_CNT_W'(TICK_CYCLES - 1))
    begin
      state_next.tick_cnt = '0;
      state_next.tag      = state_reg.tag + 8'h01; // RULE11
    end
    else
    begin
      state_next.tick_cnt = state_reg.tick_cnt + TICK_CNT_W'(1); // RULE11
    end

    // Mode and mask registers; untouched by programmed reset
    if (bus.wr_stb)
    begin
      unique case (bus.reg_num)
        REG_MODE:    state_next.mode    = {bus.wdata[MODE_SEL], bus.wdata[MODE_ALL],
                                           bus.wdata[MODE_DECL]}; // RULE12 RULE13
        REG_MASK_LO: state_next.mask_lo = bus.wdata; // RULE16
        REG_MASK_HI: state_next.mask_hi = bus.wdata; // RULE17
        default:     ;
      endcase
    end

    // Self-test and programmed reset sequencing
    unique case (state_reg.st)
      ST_IDLE:
      begin
        if (wr_srst)
        begin
          state_next.st       = ST_SRST; // RULE8
          state_next.srst_cnt = '0;
        end
        else if (wr_bit)
        begin
          state_next.st      = ST_BIT; // RULE1
          state_next.bit_cnt = '0;
          state_next.lfsr    = LFSR_SEED;
          state_next.fail_a  = 1'b0;
          state_next.fail_b  = 1'b0;
        end
      end
      ST_SRST:
      begin
        state_next.halted = 1'b1; // RULE9
        if (wr_bit)
        begin
          state_next.st      = ST_BIT; // RULE1
          state_next.bit_cnt = '0;
          state_next.lfsr    = LFSR_SEED;
          state_next.fail_a  = 1'b0;
          state_next.fail_b  = 1'b0;
        end
        else if (state_reg.srst_cnt == SRST_CNT_W'(SRST_CYC - 1))
        begin
          state_next.st = ST_IDLE; // RULE8
        end
        else
        begin
          state_next.srst_cnt = state_reg.srst_cnt + SRST_CNT_W'(1);
        end
      end
      ST_BIT:
      begin
        state_next.lfsr = {state_reg.lfsr[0], state_reg.lfsr[7:1]}
                          ^ {1'b0, state_reg.lfsr[0], 1'b0, state_reg.lfsr[0],
                             state_reg.lfsr[0], 3'h0};
        if (rx_a != enc_bit)
        begin
          state_next.fail_a = 1'b1; // RULE6
        end
        if (rx_b != enc_bit)
        begin
          state_next.fail_b = 1'b1; // RULE6
        end
        if (state_reg.bit_cnt == BIT_CNT_W'(BIT_CYCLES - 1))
        begin
          state_next.st     = ST_IDLE; // RULE1
          state_next.halted = 1'b0;
        end
        else
        begin
          state_next.bit_cnt = state_reg.bit_cnt + BIT_CNT_W'(1); // RULE1
        end
      end
      default:
      begin
        state_next.st = ST_IDLE;
      end
    endcase

    // Monitor recording of accepted commands
    if (cmd_accept && mon_en && mon_hit)
    begin
      state_next.mon_rec = 1'b1; // RULE12 RULE20
    end

    // Register reads; unmapped numbers read zero
    if (bus.rd_stb)
    begin
      state_next.rd_valid = 1'b1;
      state_next.rdata    = 16'h0000;
      unique case (bus.reg_num)
        REG_STATUS:  state_next.rdata[STS_BIT_BUSY] = (state_reg.st == ST_BIT); // RULE2
        REG_RESULT:
        begin
          state_next.rdata[RES_CHA_FAIL] = state_reg.fail_a; // RULE4 RULE6
          state_next.rdata[RES_CHB_FAIL] = state_reg.fail_b; // RULE4 RULE6
        end
        REG_MODE:
        begin
          state_next.rdata[MODE_SEL]  = state_reg.mode[2];
          state_next.rdata[MODE_ALL]  = state_reg.mode[1];
          state_next.rdata[MODE_DECL] = state_reg.mode[0];
        end
        REG_MASK_LO: state_next.rdata = state_reg.mask_lo;
        REG_MASK_HI: state_next.rdata = state_reg.mask_hi;
        default:     ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg          <= '0;
      state_reg.st       <= ST_IDLE;
      state_reg.lfsr     <= LFSR_SEED;
      state_reg.mode     <= MODE_RST;
      state_reg.mask_lo  <= MASK_RST; // RULE9
      state_reg.mask_hi  <= MASK_RST;
    end
    else if (ce)
    begin
      state_reg <= state_next;
    end
  end

endmodule : strm_dev

// ==== strm_host.sv ====
/*
  Host end: turns user register requests into strm_if strobes, keeps the
  host-side ordering and mode-setting obligations, and refuses the
  reserved register.
  Assumes same ref_clk as the device end.
*/
module strm_host
  import strm_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic        ce,
  strm_if.host             bus,
  input  wire logic        rt_mode,
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic [4:0]  req_num,
  input  wire logic [15:0] req_data,
  output logic             req_ready,
  output logic             req_refused,
  output logic             rsp_valid,
  output logic [15:0]      rsp_data
);
  import strm_pkg::*;

  typedef struct packed {
    strm_host_state_e st;
    logic             armed;
    logic [4:0]       num;
    logic             wr;
    logic             rd;
    logic [15:0]      wdata;
    logic             refused;
    logic             rsp_v;
    logic [15:0]      rsp_d;
  } strm_host_s;

  strm_host_s state_reg;
  strm_host_s state_next;
  logic [15:0] data_fix;

  assign req_ready   = (state_reg.st == H_IDLE);
  assign req_refused = state_reg.refused;
  assign rsp_valid   = state_reg.rsp_v;
  assign rsp_data    = state_reg.rsp_d;
  assign bus.reg_num = state_reg.num;
  assign bus.wr_stb  = state_reg.wr;
  assign bus.rd_stb  = state_reg.rd;
  assign bus.wdata   = state_reg.wdata;

  // Mode word clean-up
  always_comb
  begin
    data_fix = req_data;
    if (req_num == REG_MODE)
    begin
      if (rt_mode)
      begin
        data_fix[MODE_SEL]  = 1'b0; // RULE15
        data_fix[MODE_ALL]  = 1'b0; // RULE15
        data_fix[MODE_DECL] = 1'b0; // RULE15
      end
      else if (req_data[MODE_SEL] && !req_data[MODE_ALL] && !req_data[MODE_DECL])
      begin
        data_fix[MODE_DECL] = 1'b1; // RULE14
      end
    end
  end

  always_comb
  begin
    state_next         = state_reg;
    state_next.wr      = 1'b0;
    state_next.rd      = 1'b0;
    state_next.refused = 1'b0;
    state_next.rsp_v   = 1'b0;
    unique case (state_reg.st)
      H_IDLE:
      begin
        if (req_valid)
        begin
          state_next.num   = req_num;
          state_next.wdata = data_fix;
          if (req_num == REG_RSVD)
          begin
            state_next.refused = 1'b1; // RULE19
          end
          else if (req_write && req_num == REG_BIT_START && !state_reg.armed)
          begin
            state_next.num   = REG_SOFT_RST; // RULE3
            state_next.wr    = 1'b1;
            state_next.armed = 1'b1;
            state_next.st    = H_PRE;
          end
          else if (req_write)
          begin
            state_next.wr = 1'b1;
            if (req_num == REG_SOFT_RST)
            begin
              state_next.armed = 1'b1;
            end
            else if (req_num == REG_BIT_START)
            begin
              state_next.armed = 1'b0;
            end
          end
          else
          begin
            state_next.rd = 1'b1;
            state_next.st = H_RD;
          end
        end
      end
      H_PRE:
      begin
        state_next.num   = REG_BIT_START; // RULE3
        state_next.wr    = 1'b1;
        state_next.armed = 1'b0;
        state_next.st    = H_IDLE;
      end
      H_RD:
      begin
        if (bus.rd_valid)
        begin
          state_next.rsp_v = 1'b1;
          state_next.rsp_d = bus.rdata;
          state_next.st    = H_IDLE;
        end
      end
      default:
      begin
        state_next.st = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg    <= '0;
      state_reg.st <= H_IDLE;
    end
    else if (ce)
    begin
      state_reg <= state_next;
    end
  end

endmodule : strm_host

// ==== strm_if.sv ====
/*
  Register port between the host end and the device end.
  Assumes both ends share ref_clk; strobes are one-cycle pulses.
*/
interface strm_if;
  logic [4:0]  reg_num;
  logic        wr_stb;
  logic        rd_stb;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        rd_valid;

  modport dev (
    input  reg_num,
    input  wr_stb,
    input  rd_stb,
    input  wdata,
    output rdata,
    output rd_valid
  );

  modport host (
    output reg_num,
    output wr_stb,
    output rd_stb,
    output wdata,
    input  rdata,
    input  rd_valid
  );
endinterface : strm_if

// ==== strm_pkg.sv ====
/*
  Shared constants and types for the self-test, programmed reset, time tag
  and monitor select register bank and for the host end that drives it.
  Assumes a 100 MHz ref_clk and 16-bit registers selected by number.
*/
package strm_pkg;

  localparam int CLK_NS     = 10;
  localparam int BIT_US     = 100;
  localparam int BIT_CYC    = BIT_US * 1000 / CLK_NS;
  localparam int TICK_US    = 64;
  localparam int TICK_CYC   = TICK_US * 1000 / CLK_NS;
  localparam int SRST_NS    = 1000;
  localparam int SRST_CYC   = (SRST_NS - 1) / CLK_NS;
  localparam int BIT_CNT_W  = 16;
  localparam int TICK_CNT_W = 16;
  localparam int SRST_CNT_W = 8;

  localparam logic [4:0] REG_STATUS    = 5'h01;
  localparam logic [4:0] REG_RESULT    = 5'h04;
  localparam logic [4:0] REG_BIT_START = 5'h0b;
  localparam logic [4:0] REG_SOFT_RST  = 5'h0c;
  localparam logic [4:0] REG_TIMER_CLR = 5'h0d;
  localparam logic [4:0] REG_MODE      = 5'h0e;
  localparam logic [4:0] REG_RSVD      = 5'h0f;
  localparam logic [4:0] REG_MASK_LO   = 5'h10;
  localparam logic [4:0] REG_MASK_HI   = 5'h11;

  localparam int STS_BIT_BUSY = 9;
  localparam int RES_CHA_FAIL = 14;
  localparam int RES_CHB_FAIL = 15;
  localparam int MODE_SEL     = 15;
  localparam int MODE_ALL     = 14;
  localparam int MODE_DECL    = 13;
  localparam int CMD_TA_MSB   = 15;
  localparam int CMD_TA_LSB   = 11;

  localparam logic [2:0]  MODE_RST  = 3'h0;
  localparam logic [15:0] MASK_RST  = 16'h0000;
  localparam logic [7:0]  LFSR_SEED = 8'h01;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SRST = 2'b01,
    ST_BIT  = 2'b10
  } strm_dev_state_e;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_PRE  = 2'b01,
    H_RD   = 2'b10
  } strm_host_state_e;

endpackage : strm_pkg

// ==== strm_properties.sv ====
/*
  Checker on the strm_if register port between host end and device end.
  Assumes one ref_clk domain, arst_n active low, ce held high.
*/
module strm_checker
#(
  parameter int BIT_CYCLES = strm_pkg::BIT_CYC
)
(
  input wire logic        ref_clk,
  input wire logic        arst_n,
  input wire logic [4:0]  reg_num,
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic        rd_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  import strm_pkg::*;

  typedef struct packed {
    logic        armed;
    logic [15:0] bit_cnt;
    logic [15:0] lo;
    logic [15:0] hi;
  } strm_chk_s;

  strm_chk_s chk_reg;
  strm_chk_s chk_next;
  logic      wr_bit;

  assign wr_bit = wr_stb && reg_num == REG_BIT_START;

  // Shadow of the host writes, plus a margin counter around the self-test
  always_comb
  begin
    chk_next = chk_reg;
    if (chk_reg.bit_cnt != 16'h0000)
      chk_next.bit_cnt = chk_reg.bit_cnt - 16'h0001;
    if (wr_stb && reg_num == REG_SOFT_RST)
      chk_next.armed = 1'b1;
    if (wr_bit)
    begin
      chk_next.armed   = 1'b0;
      chk_next.bit_cnt = 16'(BIT_CYCLES + 4);
    end
    if (wr_stb && reg_num == REG_MASK_LO)
      chk_next.lo = wdata;
    if (wr_stb && reg_num == REG_MASK_HI)
      chk_next.hi = wdata;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      chk_reg <= '{armed: 1'b0, bit_cnt: 16'h0000, lo: MASK_RST, hi: MASK_RST};
    else
      chk_reg <= chk_next;
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  AST_RD_ANSWER: assert property (rd_stb |=> rd_valid)
    else $error("read answer missing");
  AST_RD_ASKED: assert property (rd_valid |-> $past(rd_stb))
    else $error("read answer without request");
  AST_BIT_ARMED: assert property (wr_bit |-> chk_reg.armed)
    else $error("self-test start without programmed reset");
  AST_RSVD_UNTOUCHED: assert property (!((wr_stb || rd_stb) && reg_num == REG_RSVD))
    else $error("reserved register accessed");
  AST_MODE_TARGET: assert property (wr_stb && reg_num == REG_MODE && wdata[MODE_SEL] |->
    wdata[MODE_ALL] || wdata[MODE_DECL])
    else $error("monitor enabled without target bits");
  AST_BIT_BUSY: assert property (rd_stb && reg_num == REG_STATUS &&
    chk_reg.bit_cnt inside {[8:BIT_CYCLES + 3]} |=> rdata[STS_BIT_BUSY])
    else $error("busy flag low during self-test");
  AST_BIT_DONE: assert property (rd_stb && reg_num == REG_STATUS && chk_reg.bit_cnt == 0
    |=> !rdata[STS_BIT_BUSY])
    else $error("busy flag high after self-test");
  AST_MASK_LO_KEPT: assert property (rd_stb && reg_num == REG_MASK_LO |=> rdata == chk_reg.lo)
    else $error("low mask lost");
  AST_MASK_HI_KEPT: assert property (rd_stb && reg_num == REG_MASK_HI |=> rdata == chk_reg.hi)
    else $error("high mask lost");

  COV_BIT: cover property (wr_bit);
  COV_SRST: cover property (wr_stb && reg_num == REG_SOFT_RST);
  COV_MASK: cover property (rd_stb && reg_num == REG_MASK_HI);
endmodule : strm_checker
